// ### logic/bit_skip_call_clear_decode.sv
`timescale 1ns/1ns
// What this block does
// - Opcode 0111 bbbf ffff tests a bit
// - Bit set skips next; clear leaves flags
// - Skip discards prefetch, runs a nop cycle
// - Opcode 1001 kkkk kkkk is call
// - Call pushes PC plus one on stack
// - Call literal loads PC bits 7..0
// - Status bits 6..5 feed PC 10..9
// - PC bit 8 zero, two cycles, flags kept
// - Clear accumulator zeroes it, sets zero flag
module bit_skip_call_clear_decode (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Fetch pipeline
   input wire logic instr_valid,
   input wire logic [11:0] instr,
   input wire logic [10:0] pc,
   // Register file read port
   output logic [4:0] reg_rd_addr,
   input wire logic [7:0] reg_rd_data,
   input wire logic [7:0] status,
   // Results
   output logic [7:0] acc,
   output logic zero_flag_set,
   output logic flush,
   output logic stall,
   output logic pc_load,
   output logic [10:0] pc_target,
   output logic stack_push,
   output logic [10:0] top_of_return_stack
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   decode_if dif ();
   assign dif.instr = instr;
   instr_decode u_dec (
      .d(dif)
   );

   // ----------------------------------------
   // Execute state
   // ----------------------------------------
   // Cycle two of a skip or call treats the fetched word as a nop
   typedef enum logic [1:0] {
      EXEC = 2'b00,
      BUBBLE = 2'b01
   } exec_e;

   // ----------------------------------------
   // Registers and next values
   // ----------------------------------------
   exec_e state_reg;
   exec_e state_next;
   logic [7:0] acc_reg;
   logic [7:0] acc_next;
   logic zero_reg;
   logic zero_next;
   logic flush_reg;
   logic flush_next;
   logic pc_load_reg;
   logic pc_load_next;
   logic [10:0] pc_target_reg;
   logic [10:0] pc_target_next;
   logic push_reg;
   logic push_next;
   logic [10:0] tos_reg;
   logic [10:0] tos_next;

   // ----------------------------------------
   // Combinational helpers
   // ----------------------------------------
   logic live;
   logic bit_hit;
   logic take_skip;
   logic take_call;
   logic take_clear;
   logic [1:0] page_bits;
   logic [10:0] return_addr;

   // ----------------------------------------
   // Operand views
   // ----------------------------------------
   assign reg_rd_addr = dif.reg_addr;
   // Register file answers in the same cycle, so no wait state is needed
   assign bit_hit = reg_rd_data[dif.bit_sel];
   assign page_bits = status[exec_pkg::STATUS_PAGE_MSB:exec_pkg::STATUS_PAGE_LSB];
   // Wraps at the top of program memory, as the counter itself does
   assign return_addr = pc + 11'h001;

   // ----------------------------------------
   // Instruction qualification
   // ----------------------------------------
   // Only the prefetched word is thrown away, never a later one
   assign live = instr_valid && state_reg == EXEC;
   // Opcodes exclude each other, so at most one of these is high
   assign take_skip = live && dif.is_skip_set && bit_hit;
   assign take_call = live && dif.is_call;
   assign take_clear = live && dif.is_clear_acc;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         EXEC: begin
            if (take_skip) begin
               state_next = BUBBLE;
            end else if (take_call) begin
               state_next = BUBBLE;
            end
         end
         BUBBLE: begin
            // Whatever word arrives next is the discarded one
            if (instr_valid) begin
               state_next = EXEC;
            end
         end
         default: begin
            state_next = EXEC;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= EXEC;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Accumulator and zero flag
   // ----------------------------------------
   always_comb begin
      acc_next = acc_reg;
      zero_next = 1'b0;
      if (take_clear) begin
         acc_next = 8'h00;
         zero_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_reg <= exec_pkg::ACC_RESET;
         zero_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         zero_reg <= zero_next;
      end
   end

   // ----------------------------------------
   // Redirect
   // ----------------------------------------
   // One flush line for both causes; the fetch unit needs no reason
   always_comb begin
      flush_next = 1'b0;
      pc_load_next = 1'b0;
      pc_target_next = pc_target_reg;
      if (take_skip) begin
         flush_next = 1'b1;
      end else if (take_call) begin
         flush_next = 1'b1;
         pc_load_next = 1'b1;
         pc_target_next = {page_bits, 1'b0, dif.literal};
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flush_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         pc_target_reg <= exec_pkg::PC_RESET;
      end else begin
         flush_reg <= flush_next;
         pc_load_reg <= pc_load_next;
         pc_target_reg <= pc_target_next;
      end
   end

   // ----------------------------------------
   // Return stack push
   // ----------------------------------------
   always_comb begin
      push_next = 1'b0;
      tos_next = tos_reg;
      if (take_call) begin
         push_next = 1'b1;
         tos_next = return_addr;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         push_reg <= 1'b0;
         tos_reg <= exec_pkg::PC_RESET;
      end else begin
         push_reg <= push_next;
         tos_reg <= tos_next;
      end
   end

   // ----------------------------------------
   // Pulse outputs
   // ----------------------------------------
   assign zero_flag_set = zero_reg;
   assign flush = flush_reg;
   assign stall = state_reg == BUBBLE;
   assign pc_load = pc_load_reg;
   assign stack_push = push_reg;

   // ----------------------------------------
   // Value outputs
   // ----------------------------------------
   assign acc = acc_reg;
   assign pc_target = pc_target_reg;
   assign top_of_return_stack = tos_reg;
endmodule

// ### logic/decode_if.sv
`timescale 1ns/1ns
interface decode_if;
   logic [11:0] instr;
   logic is_skip_set;
   logic is_call;
   logic is_clear_acc;
   logic [2:0] bit_sel;
   logic [4:0] reg_addr;
   logic [7:0] literal;
   modport dec (input instr, output is_skip_set, is_call, is_clear_acc, bit_sel, reg_addr,
      literal);
   modport core (output instr, input is_skip_set, is_call, is_clear_acc, bit_sel, reg_addr,
      literal);
endinterface

// ### logic/exec_pkg.sv
package exec_pkg;
   // ----------------------------------------
   // Opcode fields
   // ----------------------------------------
   localparam logic [3:0] OPC_SKIP_SET = 4'h7;
   localparam logic [3:0] OPC_CALL = 4'h9;
   localparam logic [11:0] OPC_CLEAR_ACC = 12'h040;
   localparam logic [11:0] OPC_NOP = 12'h000;
   localparam int OPC_TOP_MSB = 11;
   localparam int OPC_TOP_LSB = 8;
   localparam int BIT_SEL_MSB = 7;
   localparam int BIT_SEL_LSB = 5;
   localparam int REG_ADDR_MSB = 4;
   localparam int REG_ADDR_LSB = 0;
   localparam int LIT_MSB = 7;
   localparam int LIT_LSB = 0;
   // ----------------------------------------
   // Status and program counter fields
   // ----------------------------------------
   localparam int STATUS_PAGE_MSB = 6;
   localparam int STATUS_PAGE_LSB = 5;
   localparam int STATUS_ZERO_BIT = 2;
   localparam int PC_WIDTH = 11;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [10:0] PC_RESET = 11'h7FF;
endpackage

// ### logic/instr_decode.sv
`timescale 1ns/1ns
module instr_decode (
   decode_if.dec d
);
   // ----------------------------------------
   // Field extraction
   // ----------------------------------------
   always_comb begin
      d.is_skip_set = d.instr[exec_pkg::OPC_TOP_MSB:exec_pkg::OPC_TOP_LSB]
         == exec_pkg::OPC_SKIP_SET;
      d.is_call = d.instr[exec_pkg::OPC_TOP_MSB:exec_pkg::OPC_TOP_LSB]
         == exec_pkg::OPC_CALL;
      d.is_clear_acc = d.instr == exec_pkg::OPC_CLEAR_ACC;
      d.bit_sel = d.instr[exec_pkg::BIT_SEL_MSB:exec_pkg::BIT_SEL_LSB];
      d.reg_addr = d.instr[exec_pkg::REG_ADDR_MSB:exec_pkg::REG_ADDR_LSB];
      d.literal = d.instr[exec_pkg::LIT_MSB:exec_pkg::LIT_LSB];
   end
endmodule

// ### test/bit_skip_call_clear_decode_chk.sv
`timescale 1ns/1ns
module skip_call_chk (
   input wire logic clk_sys, rst, instr_valid, stall, flush, pc_load, stack_push, zero_flag_set,
   input wire logic [11:0] instr,
   input wire logic [10:0] pc, pc_target, top_of_return_stack,
   input wire logic [7:0] reg_rd_data, status, acc,
   input wire logic [4:0] reg_rd_addr
);
   // Taken only outside the bubble cycle
   wire tk = instr_valid & ~stall;
   wire skp = tk & (instr[11:8] == 4'h7);
   wire hit = reg_rd_data[instr[7:5]];
   wire cl = tk & (instr[11:8] == 4'h9);
   wire clr = tk & (instr == 12'h040);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_addr_field: assert property (reg_rd_addr == instr[4:0]) else $error("addr");
   a_skip_taken: assert property (skp & hit |=> flush & stall) else $error("skip");
   a_skip_clear: assert property (skp & ~hit |=> ~flush & ~stall & ~zero_flag_set)
      else $error("no skip");
   a_bubble_nop: assert property (stall & instr_valid |=> ~stall & ~flush & ~pc_load)
      else $error("bubble");
   a_call_push: assert property (cl |=> stack_push
      & top_of_return_stack == $past(pc) + 11'h1) else $error("push");
   a_call_low: assert property (cl |=> pc_load & pc_target[7:0] == $past(instr[7:0]))
      else $error("low");
   a_call_page: assert property (cl |=> pc_target[10:9] == $past(status[6:5])
      & ~pc_target[8]) else $error("page");
   a_call_cycles: assert property (cl |=> stall & ~zero_flag_set) else $error("cycles");
   a_clear_acc: assert property (clr |=> acc == 8'h00 & zero_flag_set) else $error("clr");
   a_zero_cause: assert property (zero_flag_set |-> $past(clr)) else $error("zero");
endmodule
bind bit_skip_call_clear_decode skip_call_chk u_chk (
   .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .stall(stall), .flush(flush),
   .pc_load(pc_load), .stack_push(stack_push), .zero_flag_set(zero_flag_set), .instr(instr),
   .pc(pc), .pc_target(pc_target), .top_of_return_stack(top_of_return_stack),
   .reg_rd_data(reg_rd_data), .status(status), .acc(acc), .reg_rd_addr(reg_rd_addr)
);

// ### test/bit_skip_call_clear_decode_tb.sv
`timescale 1ns/1ns
module bit_skip_call_clear_decode_tb;
   logic clk_sys = 1'b0, rst = 1'b1, instr_valid = 1'b0;
   logic [11:0] instr = 12'h000;
   logic [10:0] pc = 11'h000;
   logic [7:0] reg_rd_data = 8'h00, status = 8'h00;
   logic [7:0] acc;
   logic [4:0] reg_rd_addr;
   logic zero_flag_set, flush, stall, pc_load, stack_push;
   logic [10:0] pc_target, top_of_return_stack;
   int miscompares = 0, compares = 0;
   always #20 clk_sys = ~clk_sys;
   bit_skip_call_clear_decode DUT (
      .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr), .pc(pc),
      .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .status(status), .acc(acc),
      .zero_flag_set(zero_flag_set), .flush(flush), .stall(stall), .pc_load(pc_load),
      .pc_target(pc_target), .stack_push(stack_push), .top_of_return_stack(top_of_return_stack)
   );
   task chk(input logic ok);
      compares++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED %0t output mismatch", $time);
      end
   endtask
   // Valid drops between words, so pulses are looked at one edge after taking
   task issue(input logic [11:0] w, input logic [10:0] p, input logic [7:0] d, s);
      @(posedge clk_sys);
      instr <= w;
      pc <= p;
      reg_rd_data <= d;
      status <= s;
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1;
   endtask
   task skip_test;
      issue({exec_pkg::OPC_SKIP_SET, 8'hFF}, 11'h010, 8'h80, 8'h00);
      chk(flush === 1'b1 && stall === 1'b1 && reg_rd_addr === 5'h1F);
      issue(exec_pkg::OPC_NOP, 11'h011, 8'h00, 8'h00);
      chk(stall === 1'b0 && flush === 1'b0 && pc_load === 1'b0);
      issue({exec_pkg::OPC_SKIP_SET, 8'hFF}, 11'h012, 8'h7F, 8'h00);
      chk(flush === 1'b0 && stall === 1'b0 && zero_flag_set === 1'b0);
      issue({exec_pkg::OPC_SKIP_SET, 8'h25}, 11'h013, 8'hFD, 8'h00);
      chk(flush === 1'b0 && stall === 1'b0 && reg_rd_addr === 5'h05);
      $display("skip test done");
   endtask
   task call_test;
      issue({exec_pkg::OPC_CALL, 8'hFF}, 11'h7FF, 8'h00, 8'h60);
      chk(pc_load === 1'b1 && stack_push === 1'b1 && stall === 1'b1);
      chk(pc_target === 11'h6FF && top_of_return_stack === 11'h000);
      issue(exec_pkg::OPC_NOP, 11'h000, 8'h00, 8'h60);
      chk(stall === 1'b0 && stack_push === 1'b0 && zero_flag_set === 1'b0);
      issue({exec_pkg::OPC_CALL, 8'h00}, 11'h123, 8'h00, 8'h20);
      chk(pc_target === 11'h200 && top_of_return_stack === 11'h124);
      issue(exec_pkg::OPC_NOP, 11'h124, 8'h00, 8'h20);
      $display("call test done");
   endtask
   task clear_test;
      issue(exec_pkg::OPC_CLEAR_ACC, 11'h200, 8'h00, 8'h00);
      chk(acc === 8'h00 && zero_flag_set === 1'b1 && stall === 1'b0);
      issue(12'h041, 11'h201, 8'h00, 8'h00);
      chk(zero_flag_set === 1'b0);
      $display("clear test done");
   endtask
   task summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      chk(pc_target === exec_pkg::PC_RESET && top_of_return_stack === exec_pkg::PC_RESET
         && acc === exec_pkg::ACC_RESET && stall === 1'b0 && flush === 1'b0);
      rst <= 1'b0;
      skip_test;
      call_test;
      clear_test;
      summarize;
   end
   // Whole run is some twenty-six cycles; over fifteen times that is a hang
   initial begin
      #16000;
      miscompares++;
      summarize;
   end
endmodule
